// *** core/sup_user_regs.sv ***
`timescale 1ns/100ps
module sup_user_regs import sup_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [6:0] regAddr,
  input wire logic regWrEn,
  input wire logic [31:0] regWrData,
  input wire logic [3:0] regWrByteEn,
  input wire logic regReadRequest,
  output logic [31:0] regRdData,
  output logic regReadValid,
  output logic [47:0] chanStartAddr,
  output logic [47:0] chanXferLen,
  output logic [2:0] chanCommand,
  output logic chanCmdReq,
  input wire logic chanBusy,
  input wire logic chanErrorFlag,
  input wire logic [31:0] chanErrorCause,
  input wire logic [15:0] chanAdminCompletion,
  input wire logic [15:0] chanIoCompletion,
  input wire logic [47:0] chanDebugVector,
  output logic testWrValid,
  output logic [255:0] testWrData,
  input wire logic testWrReady,
  input wire logic testRdValid,
  input wire logic [255:0] testRdData,
  output logic testRdReady
);
  // word indexes of the register map
  localparam logic [6:0] ADDR_LO_IDX = sup_idx(`SUP_OFF_ADDR_LO);
  localparam logic [6:0] ADDR_HI_IDX = sup_idx(`SUP_OFF_ADDR_HI);
  localparam logic [6:0] LEN_LO_IDX = sup_idx(`SUP_OFF_LEN_LO);
  localparam logic [6:0] LEN_HI_IDX = sup_idx(`SUP_OFF_LEN_HI);
  localparam logic [6:0] CMD_IDX = sup_idx(`SUP_OFF_CMD);
  localparam logic [6:0] PATT_IDX = sup_idx(`SUP_OFF_PATT);
  localparam logic [6:0] RATE_IDX = sup_idx(`SUP_OFF_RATE);
  localparam logic [6:0] STATUS_IDX = sup_idx(`SUP_OFF_STATUS);
  localparam logic [6:0] ERR_IDX = sup_idx(`SUP_OFF_ERR);
  localparam logic [6:0] COMP_IDX = sup_idx(`SUP_OFF_COMP);
  localparam logic [6:0] DBG_LO_IDX = sup_idx(`SUP_OFF_DBG_LO);
  localparam logic [6:0] DBG_HI_IDX = sup_idx(`SUP_OFF_DBG_HI);
  localparam logic [6:0] EXP_IDX = sup_idx(`SUP_OFF_EXP_BASE);
  localparam logic [6:0] RDW_IDX = sup_idx(`SUP_OFF_RDW_BASE);
  localparam logic [6:0] FAIL_LO_IDX = sup_idx(`SUP_OFF_FAIL_LO);
  localparam logic [6:0] FAIL_HI_IDX = sup_idx(`SUP_OFF_FAIL_HI);
  localparam logic [6:0] BYTES_LO_IDX = sup_idx(`SUP_OFF_BYTES_LO);
  localparam logic [6:0] BYTES_HI_IDX = sup_idx(`SUP_OFF_BYTES_HI);

  sup_state_t st_reg;
  sup_state_t st_next;

  logic creditOk;
  logic [7:0] rateEff;
  logic beat;
  logic [31:0] rdMux;
  logic [31:0] expSel;
  logic [31:0] rdwSel;
  logic [56:0] totalBytes;
  logic [56:0] startByte;

  // merge written bytes into the old value
  function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // galois step of the tester sequence
  function automatic logic [31:0] lfsrStep(input logic [31:0] x);
    logic [31:0] r;
    r = {1'b0, x[31:1]};
    if (x[0]) begin
      r = r ^ `SUP_LFSR_TAPS;
    end
    return r;
  endfunction

  // data word for a beat, eight 32-bit lanes
  function automatic logic [255:0] patWord(input logic [2:0] sel, input logic [51:0] beatNo,
                                           input logic [31:0] seq);
    logic [255:0] w;
    logic [31:0] base;
    w = '0;
    base = {beatNo[28:0], 3'h0};
    for (int i = 0; i < 8; i++) begin
      case (sel)
        `SUP_PAT_INC: w[i*32 +: 32] = base + 32'(i);
        `SUP_PAT_DEC: w[i*32 +: 32] = ~(base + 32'(i));
        `SUP_PAT_ZERO: w[i*32 +: 32] = '0;
        `SUP_PAT_ONE: w[i*32 +: 32] = '1;
        `SUP_PAT_LFSR: w[i*32 +: 32] = seq ^ 32'(i);
        default: w[i*32 +: 32] = '0;
      endcase
    end
    return w;
  endfunction

  // sector counts to byte counts
  assign totalBytes = {st_reg.len, 9'h000};
  assign startByte = {st_reg.addr, 9'h000};

  // throttle and beat handshakes
  // rates above full act as full, so the credit never overflows
  assign rateEff = (st_reg.rate > 7'(`SUP_RATE_FULL)) ? `SUP_RATE_FULL : {1'b0, st_reg.rate};
  assign creditOk = (st_reg.credit >= `SUP_RATE_FULL);
  assign testWrValid = (st_reg.mode == SUP_WRITING) && creditOk;
  assign testRdReady = (st_reg.mode == SUP_READING) && creditOk;
  assign beat = (testWrValid && testWrReady) || (testRdValid && testRdReady);

  // next state: register writes and tester
  always_comb begin
    logic [31:0] m;
    logic [56:0] nb;
    logic [31:0] nl;
    m = '0;
    nb = st_reg.bytes + `SUP_BEAT_BYTES;
    nl = lfsrStep(st_reg.lfsr);
    st_next = st_reg;
    st_next.cmdReq = 1'b0;
    // control block writes; status block writes fall through
    if (regWrEn) begin
      if (regAddr == ADDR_LO_IDX) begin
        st_next.addr[31:0] = beMerge(st_reg.addr[31:0], regWrData, regWrByteEn);
      end else if (regAddr == ADDR_HI_IDX) begin
        m = beMerge({16'h0000, st_reg.addr[47:32]}, regWrData, regWrByteEn);
        st_next.addr[47:32] = m[15:0];
      end else if (regAddr == LEN_LO_IDX) begin
        st_next.len[31:0] = beMerge(st_reg.len[31:0], regWrData, regWrByteEn);
      end else if (regAddr == LEN_HI_IDX) begin
        m = beMerge({16'h0000, st_reg.len[47:32]}, regWrData, regWrByteEn);
        st_next.len[47:32] = m[15:0];
      end else if (regAddr == CMD_IDX) begin
        m = beMerge({29'h0, st_reg.cmd}, regWrData, regWrByteEn);
        st_next.cmd = m[2:0];
        st_next.cmdReq = 1'b1;
      end else if (regAddr == PATT_IDX) begin
        m = beMerge({29'h0, st_reg.patt}, regWrData, regWrByteEn);
        st_next.patt = m[2:0];
      end else if (regAddr == RATE_IDX) begin
        m = beMerge({25'h0, st_reg.rate}, regWrData, regWrByteEn);
        st_next.rate = m[6:0];
      end
    end
    // tester start follows the issued command
    if (st_reg.cmdReq) begin
      if ((st_reg.cmd == `SUP_CMD_WRITE) || (st_reg.cmd == `SUP_CMD_READ)) begin
        st_next.bytes = '0;
        st_next.lfsr = `SUP_LFSR_SEED;
        st_next.credit = '0;
        st_next.curWord = patWord(st_reg.patt, 52'h0, `SUP_LFSR_SEED);
        st_next.mode = SUP_IDLE;
        if (st_reg.len != '0) begin
          st_next.mode = (st_reg.cmd == `SUP_CMD_WRITE) ? SUP_WRITING : SUP_READING;
        end
        if (st_reg.cmd == `SUP_CMD_READ) begin
          st_next.fail = 1'b0;
        end
      end
    end else if (st_reg.mode != SUP_IDLE) begin
      // earn credit at the rate percentage each cycle while short of a full beat
      if (!creditOk) begin
        st_next.credit = st_reg.credit + rateEff;
      end
      if (beat) begin
        // a beat still earns this cycle's share, so 100 percent keeps one beat per cycle
        st_next.credit = st_reg.credit - `SUP_RATE_FULL + rateEff;
        st_next.bytes = nb;
        st_next.lfsr = nl;
        st_next.curWord = patWord(st_reg.patt, nb[56:5], nl);
        // first mismatch only
        if ((st_reg.mode == SUP_READING) && (testRdData != st_reg.curWord) && !st_reg.fail) begin
          st_next.fail = 1'b1;
          st_next.expW = st_reg.curWord;
          st_next.rdW = testRdData;
          st_next.failAddr = startByte + st_reg.bytes;
        end
        if (nb == totalBytes) begin
          st_next.mode = SUP_IDLE;
        end
      end
    end
  end

  // state register, frozen while clkEn is low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.rate <= `SUP_RATE_RESET;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  // channel parameters straight from the held fields
  assign chanStartAddr = st_reg.addr;
  assign chanXferLen = st_reg.len;
  assign chanCommand = st_reg.cmd;
  assign chanCmdReq = st_reg.cmdReq;
  assign testWrData = st_reg.curWord;

  // lane pickers for the captured words
  sup_word_sel uExpSel (
    .wordIn(st_reg.expW),
    .sel(regAddr[2:0]),
    .wordOut(expSel)
  );

  sup_word_sel uRdwSel (
    .wordIn(st_reg.rdW),
    .sel(regAddr[2:0]),
    .wordOut(rdwSel)
  );

  // read decode; control block and holes read zero
  always_comb begin
    rdMux = '0;
    if (regAddr == STATUS_IDX) begin
      rdMux = {29'h0, st_reg.fail, chanErrorFlag, chanBusy};
    end else if (regAddr == ERR_IDX) begin
      rdMux = chanErrorCause;
    end else if (regAddr == COMP_IDX) begin
      rdMux = {chanIoCompletion, chanAdminCompletion};
    end else if (regAddr == DBG_LO_IDX) begin
      rdMux = chanDebugVector[31:0];
    end else if (regAddr == DBG_HI_IDX) begin
      rdMux = {16'h0000, chanDebugVector[47:32]};
    end else if (regAddr[6:3] == EXP_IDX[6:3]) begin
      rdMux = expSel;
    end else if (regAddr[6:3] == RDW_IDX[6:3]) begin
      rdMux = rdwSel;
    end else if (regAddr == FAIL_LO_IDX) begin
      rdMux = st_reg.failAddr[31:0];
    end else if (regAddr == FAIL_HI_IDX) begin
      rdMux = {7'h00, st_reg.failAddr[56:32]};
    end else if (regAddr == BYTES_LO_IDX) begin
      rdMux = st_reg.bytes[31:0];
    end else if (regAddr == BYTES_HI_IDX) begin
      rdMux = {7'h00, st_reg.bytes[56:32]};
    end
  end

  // three-stage answer pipeline
  sup_rd_delay uRdDelay (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .reqIn(regReadRequest),
    .dataIn(rdMux),
    .validOut(regReadValid),
    .dataOut(regRdData)
  );
endmodule // sup_user_regs

// *** core/sup_cfg.svh ***
`ifndef SUP_CFG_SVH
`define SUP_CFG_SVH

// control block offsets, byte addresses, write only
`define SUP_OFF_ADDR_LO 16'h0000
`define SUP_OFF_ADDR_HI 16'h0004
`define SUP_OFF_LEN_LO 16'h0008
`define SUP_OFF_LEN_HI 16'h000C
`define SUP_OFF_CMD 16'h0010
`define SUP_OFF_PATT 16'h0014
`define SUP_OFF_RATE 16'h0018

// status block offsets, byte addresses, read only
`define SUP_OFF_STATUS 16'h0100
`define SUP_OFF_ERR 16'h0104
`define SUP_OFF_COMP 16'h0108
`define SUP_OFF_DBG_LO 16'h0110
`define SUP_OFF_DBG_HI 16'h0114
`define SUP_OFF_EXP_BASE 16'h0140
`define SUP_OFF_RDW_BASE 16'h0160
`define SUP_OFF_FAIL_LO 16'h0180
`define SUP_OFF_FAIL_HI 16'h0184
`define SUP_OFF_BYTES_LO 16'h0188
`define SUP_OFF_BYTES_HI 16'h018C

// command codes
`define SUP_CMD_IDENTIFY 3'h0
`define SUP_CMD_SHUTDOWN 3'h1
`define SUP_CMD_WRITE 3'h2
`define SUP_CMD_READ 3'h3
`define SUP_CMD_HEALTH 3'h4
`define SUP_CMD_FLUSH 3'h6

// test pattern codes
`define SUP_PAT_INC 3'h0
`define SUP_PAT_DEC 3'h1
`define SUP_PAT_ZERO 3'h2
`define SUP_PAT_ONE 3'h3
`define SUP_PAT_LFSR 3'h4

// rate throttle and data path figures
`define SUP_RATE_FULL 8'h64
`define SUP_RATE_RESET 7'h64
`define SUP_BEAT_BYTES 57'h20
`define SUP_LFSR_SEED 32'h00000001
`define SUP_LFSR_TAPS 32'h80200003
`define SUP_RD_LATENCY 3

`endif

// *** core/sup_pkg.sv ***
package sup_pkg;
  `include "sup_cfg.svh"

  // tester activity
  typedef enum logic [1:0] {SUP_IDLE, SUP_WRITING, SUP_READING} sup_tmode_t;

  // whole state of the register bank and tester
  typedef struct packed {
    logic [47:0] addr;
    logic [47:0] len;
    logic [2:0] cmd;
    logic cmdReq;
    logic [2:0] patt;
    logic [6:0] rate;
    sup_tmode_t mode;
    logic [56:0] bytes;
    logic [31:0] lfsr;
    logic [7:0] credit;
    logic [255:0] curWord;
    logic fail;
    logic [255:0] expW;
    logic [255:0] rdW;
    logic [56:0] failAddr;
  } sup_state_t;

  // read answer pipeline state
  typedef struct packed {
    logic [`SUP_RD_LATENCY-1:0] vld;
    logic [`SUP_RD_LATENCY-1:0][31:0] dat;
  } sup_pipe_t;

  // byte offset to word index on the register port
  function automatic logic [6:0] sup_idx(input logic [15:0] off);
    return off[8:2];
  endfunction
endpackage

// *** core/sup_rd_delay.sv ***
`timescale 1ns/100ps
module sup_rd_delay import sup_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic reqIn,
  input wire logic [31:0] dataIn,
  output logic validOut,
  output logic [31:0] dataOut
);
  sup_pipe_t pipe_reg;
  sup_pipe_t pipe_next;

  // shift request and data along the stages
  always_comb begin
    pipe_next = pipe_reg;
    pipe_next.vld[0] = reqIn;
    pipe_next.dat[0] = dataIn;
    for (int i = 1; i < `SUP_RD_LATENCY; i++) begin
      pipe_next.vld[i] = pipe_reg.vld[i-1];
      pipe_next.dat[i] = pipe_reg.dat[i-1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pipe_reg <= '0;
    end else if (clkEn) begin
      pipe_reg <= pipe_next;
    end
  end

  // last stage is the answer
  assign validOut = pipe_reg.vld[`SUP_RD_LATENCY-1];
  assign dataOut = pipe_reg.dat[`SUP_RD_LATENCY-1];
endmodule // sup_rd_delay

// *** core/sup_word_sel.sv ***
`timescale 1ns/100ps
module sup_word_sel (
  input wire logic [255:0] wordIn,
  input wire logic [2:0] sel,
  output logic [31:0] wordOut
);
  logic [31:0] lanes [8];

  // split the wide word into 32-bit lanes, lowest lane first
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gLane
      assign lanes[g] = wordIn[g*32 +: 32];
    end
  endgenerate

  assign wordOut = lanes[sel];
endmodule // sup_word_sel

// *** sim/sup_user_regs_properties.sv ***
`timescale 1ns/100ps
module sup_user_regs_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [6:0] regAddr,
  input wire logic regWrEn,
  input wire logic [31:0] regWrData,
  input wire logic [3:0] regWrByteEn,
  input wire logic regReadRequest,
  input wire logic [31:0] regRdData,
  input wire logic regReadValid,
  input wire logic [47:0] chanStartAddr,
  input wire logic [47:0] chanXferLen,
  input wire logic [2:0] chanCommand,
  input wire logic chanCmdReq,
  input wire logic chanBusy,
  input wire logic chanErrorFlag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n || !clkEn);
  // command write, and the read answer three edges on
  sequence s_cmd_wr;
    regWrEn && regAddr == 7'h04;
  endsequence
  sequence s_answer;
    ##3 regReadValid;
  endsequence
  a_read_latency: assert property (regReadRequest |-> s_answer) else $error("read answer late");
  a_valid_cause: assert property (regReadValid |-> $past(regReadRequest, 3)) else $error("stray valid");
  a_cmd_pulse: assert property (s_cmd_wr |=> chanCmdReq) else $error("no command request");
  a_cmd_cause: assert property (chanCmdReq |-> $past(regWrEn && regAddr == 7'h04)) else $error("stray req");
  a_cmd_code: assert property (regWrEn && regAddr == 7'h04 && regWrByteEn[0]
    |=> chanCommand == $past(regWrData[2:0])) else $error("bad command code");
  a_addr_low: assert property (regWrEn && regAddr == 7'h00 && regWrByteEn == 4'hF
    |=> chanStartAddr[31:0] == $past(regWrData)) else $error("bad address low");
  a_params_hold: assert property (!regWrEn || regAddr[6]
    |=> $stable(chanStartAddr) && $stable(chanXferLen) && $stable(chanCommand)) else $error("param moved");
  a_status_bits: assert property (regReadRequest && regAddr == 7'h40
    |-> ##3 regRdData[1:0] == {$past(chanErrorFlag, 3), $past(chanBusy, 3)}) else $error("bad status");
  a_ctrl_zero: assert property (regReadRequest && !regAddr[6] |-> ##3 regRdData == 32'h0) else $error("ctrl read");
endmodule // sup_user_regs_properties

bind sup_user_regs sup_user_regs_properties u_props (.sys_clk, .rst_n, .clkEn, .regAddr, .regWrEn, .regWrData,
  .regWrByteEn, .regReadRequest, .regRdData, .regReadValid, .chanStartAddr, .chanXferLen, .chanCommand,
  .chanCmdReq, .chanBusy, .chanErrorFlag);

// *** sim/sup_chan_model.sv ***
`timescale 1ns/100ps
module sup_chan_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [7:0] badBeat,
  input wire logic [2:0] chanCommand,
  input wire logic chanCmdReq,
  input wire logic testRdReady,
  output logic chanBusy,
  output logic chanErrorFlag,
  output logic testWrReady,
  output logic testRdValid,
  output logic [255:0] testRdData
);
  logic [3:0] busyCnt;
  logic [7:0] beat;
  logic phase;
  // busy window and reserved-code error after each request
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      busyCnt <= 4'h0;
      beat <= 8'h00;
      phase <= 1'b0;
      chanErrorFlag <= 1'b0;
    end else begin
      phase <= ~phase;
      if (testRdValid && testRdReady)
        beat <= beat + 8'h01;
      if (busyCnt != 4'h0)
        busyCnt <= busyCnt - 4'h1;
      if (chanCmdReq) begin
        busyCnt <= 4'h8;
        beat <= 8'h00;
        chanErrorFlag <= chanCommand[2] & chanCommand[0];
      end
    end
  end
  assign chanBusy = busyCnt != 4'h0;
  // slow mode offers a beat every other cycle
  assign testWrReady = !slow || phase;
  assign testRdValid = testWrReady;
  // incrementing lanes, lane 0 hurt on the chosen beat, inverted when idle
  always_comb begin
    for (int i = 0; i < 8; i++)
      testRdData[32*i +: 32] = {21'h0, beat, i[2:0]} ^ {31'h0, beat == badBeat && i == 0} ^ {32{!testRdValid}};
  end
endmodule // sup_chan_model

// *** sim/sup_user_regs_tb.sv ***
`timescale 1ns/100ps
module sup_user_regs_tb;
  localparam logic [31:0] ERR = 32'h5A5A0F0F;
  localparam logic [15:0] ADM = 16'h1234;
  localparam logic [15:0] IOC = 16'hBEEF;
  localparam logic [47:0] DBG = 48'h00CAFE123456;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] regAddr = 7'h00;
  logic regWrEn = 1'b0;
  logic [31:0] regWrData = 32'h0;
  logic [3:0] regWrByteEn = 4'hF;
  logic regReadRequest = 1'b0;
  logic slow = 1'b0;
  logic [7:0] badBeat = 8'h05;
  logic [31:0] regRdData, v;
  logic regReadValid, chanCmdReq, chanBusy, chanErrorFlag, testWrReady, testRdValid, testRdReady;
  logic [47:0] chanStartAddr, chanXferLen;
  logic [2:0] chanCommand;
  logic [255:0] testRdData;
  logic [2:0] cmds [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h5};
  int bad_count = 0;
  int cmp_count = 0;
  always #4 sys_clk = ~sys_clk;
  sup_user_regs dut (.sys_clk, .rst_n, .clkEn(1'b1), .regAddr, .regWrEn, .regWrData, .regWrByteEn,
    .regReadRequest, .regRdData, .regReadValid, .chanStartAddr, .chanXferLen, .chanCommand, .chanCmdReq,
    .chanBusy, .chanErrorFlag, .chanErrorCause(ERR), .chanAdminCompletion(ADM), .chanIoCompletion(IOC),
    .chanDebugVector(DBG), .testWrValid(), .testWrData(), .testWrReady, .testRdValid, .testRdData, .testRdReady);
  sup_chan_model model (.sys_clk, .rst_n, .slow, .badBeat, .chanCommand, .chanCmdReq, .testRdReady,
    .chanBusy, .chanErrorFlag, .testWrReady, .testRdValid, .testRdData);
  // compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    #1 regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge sys_clk);
    #1 regWrEn = 1'b0;
  endtask
  // read request, answer looked at in its one valid cycle
  task automatic rd(input logic [6:0] a);
    @(posedge sys_clk);
    #1 regAddr = a;
    regReadRequest = 1'b1;
    @(posedge sys_clk);
    #1 regReadRequest = 1'b0;
    @(posedge sys_clk);
    #1 chk(regReadValid, 1'b0);
    @(posedge sys_clk);
    #1 chk(regReadValid, 1'b1);
    v = regRdData;
  endtask
  task automatic rc(input logic [6:0] a, input logic [31:0] exp);
    rd(a);
    chk(v, exp);
  endtask
  // poll the tested byte count until one block is done
  task automatic wait_done;
    v = 32'h0;
    for (int k = 0; k < 50 && v !== 32'h200; k++)
      rd(7'h62);
    chk(v, 32'h200);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    wr(7'h00, 32'h00000002);
    regWrByteEn = 4'h1;
    wr(7'h00, 32'hFFFFFF07);
    regWrByteEn = 4'hF;
    wr(7'h01, 32'hFFFF0001);
    wr(7'h02, 32'h00000001);
    wr(7'h03, 32'hABCD0000);
    chk(chanStartAddr, 48'h000100000007);
    chk(chanXferLen, 48'h000000000001);
    rc(7'h00, 32'h0);
    wr(7'h41, 32'hFFFFFFFF);
    rc(7'h41, ERR);
    rc(7'h42, {IOC, ADM});
    rc(7'h44, DBG[31:0]);
    rc(7'h45, {16'h0, DBG[47:32]});
    foreach (cmds[k]) begin
      wr(7'h04, {29'h0, cmds[k]});
      chk(chanCmdReq, 1'b1);
      chk(chanCommand, cmds[k]);
    end
    rc(7'h40, 32'h3);
    wr(7'h05, 32'h0);
    wr(7'h06, 32'h64);
    slow = 1'b1;
    wr(7'h04, 32'h3);
    wait_done;
    rc(7'h63, 32'h0);
    rc(7'h40, 32'h4);
    rc(7'h50, 32'h28);
    rc(7'h57, 32'h2F);
    rc(7'h58, 32'h29);
    rc(7'h5F, 32'h2F);
    rc(7'h60, 32'h00000EA0);
    rc(7'h61, 32'h200);
    wr(7'h05, 32'h1);
    wr(7'h04, 32'h3);
    wait_done;
    rc(7'h50, 32'hFFFFFFFF);
    rc(7'h60, 32'h00000E00);
    final_report;
  end
  // watchdog
  initial begin
    #20000;
    bad_count++;
    final_report;
  end
endmodule // sup_user_regs_tb
